// File: inc/fspp_regs.svh
// constants for the flash self-program protection block
// assumes lock and fuse bits arrive as stored levels, 1 = unprogrammed
//
// Functional notes
// RL1: lock and fuse bits read 1 as unprogrammed, 0 as programmed.
// RL2: software may program lock bits; only chip erase unprograms them. Here NRST_IN also reloads them to all ones.
// RL3: general write lock has no say over store instructions.
// RL4: general read/write lock restricts neither reads nor stores.
// RL5: application mode 1 leaves application access unrestricted.
// RL6: application mode 2 refuses stores to application, allows reads.
// RL7: application mode 3 refuses stores and boot-code reads of application.
// RL8: application mode 4 refuses boot-code reads of application only.
// RL9: application modes 3/4 with vectors in boot mask interrupts in application.
// RL10: boot mode 1 leaves boot access unrestricted.
// RL11: boot mode 2 refuses stores into the boot section.
// RL12: boot mode 3 refuses stores and application-code reads of boot.
// RL13: boot mode 4 refuses application-code reads of boot only.
// RL14: boot modes 3/4 with vectors in application mask interrupts in boot.
// RL15: reset vector is 0x0000 if fuse unprogrammed, else boot start.
// RL16: running code can never change a fuse.
// RL17: address is high pair byte over low pair byte.
// RL18: low address bits index word in page, high bits the page.
// RL19: software must erase and write the same page.
// RL20: target address is captured when an operation starts.
// RL21: lock-bit store ignores the address pair entirely.
// RL22: program reads are byte addressed, bit 0 picks the byte.
// RL23: stores start only when fetched from the boot section.
// RL24: undecodable lock patterns resolve to the more restrictive permission.
`ifndef FSPP_REGS_SVH
`define FSPP_REGS_SVH
`define FSPP_UNPROG        1'b1
`define FSPP_APP_RESET_VEC 16'h0000
`define FSPP_LOCK_RST      6'h3f
`define FSPP_BOOT_START    16'h1c00
`define FSPP_WORD_BITS     6
`endif

// File: inc/fspp_pkg.sv
// types for the flash self-program protection block
// assumes nothing beyond the constants header
package fspp_pkg;
   typedef enum logic [1:0] {
      FSPP_IDLE = 2'b00,
      FSPP_BUSY = 2'b01
   } fspp_state_t;
   typedef enum logic [1:0] {
      FSPP_OP_ERASE = 2'b00,
      FSPP_OP_WRITE = 2'b01,
      FSPP_OP_FILL  = 2'b10,
      FSPP_OP_LOCK  = 2'b11
   } fspp_op_t;
endpackage

// File: verilog/fspp_top.sv
// flash self-program protection: lock decode, reset vector, address split
// assumes the cpu core presents one request per cycle, synchronous to CLOCK_IN
`include "fspp_regs.svh"
module fspp_top
   import fspp_pkg::*;
#(
   parameter int WORD_BITS = `FSPP_WORD_BITS,
   parameter logic [15:0] BOOT_START = `FSPP_BOOT_START,
   parameter int OP_CYCLES = 4
) (
   input  wire logic        CLOCK_IN,
   input  wire logic        NRST_IN,
   input  wire logic        CE_IN,
   input  wire logic        CHIP_ERASE_IN,
   input  wire logic        BOOT_RESET_FUSE_IN,
   input  wire logic        VECTORS_IN_BOOT_IN,
   input  wire logic [15:0] EXEC_PC_IN,
   input  wire logic        STORE_REQ_IN,
   input  wire fspp_op_t    STORE_OP_IN,
   input  wire logic [7:0]  ADDR_PAIR_HIGH_IN,
   input  wire logic [7:0]  ADDR_PAIR_LOW_IN,
   input  wire logic [7:0]  LOCK_DATA_IN,
   input  wire logic        READ_REQ_IN,
   output logic             STORE_START_OUT,
   output logic             STORE_REFUSED_OUT,
   output logic             BUSY_OUT,
   output logic [15:0]      PAGE_INDEX_OUT,
   output logic [15:0]      WORD_IN_PAGE_OUT,
   output logic             READ_GRANT_OUT,
   output logic             READ_REFUSED_OUT,
   output logic [15:0]      READ_WORD_ADDR_OUT,
   output logic             READ_HIGH_BYTE_OUT,
   output logic             IRQ_BLOCK_OUT,
   output logic [15:0]      RESET_VECTOR_OUT,
   output logic [5:0]       LOCK_BITS_OUT
);

   initial begin
      if (WORD_BITS < 1 || WORD_BITS > 15) $error("WORD_BITS out of range");
      if (OP_CYCLES < 1 || OP_CYCLES > 255) $error("OP_CYCLES out of range");
   end

   ////////////////////////////////////////////////////////////////////////////
   // decode helpers
   // field is {hi, lo}; 1 = unprogrammed
   function automatic logic no_write(input logic [1:0] f);
      return f != {`FSPP_UNPROG, `FSPP_UNPROG} && f != {1'b0, `FSPP_UNPROG};
   endfunction
   function automatic logic no_cross_read(input logic [1:0] f);
      return f[1] != `FSPP_UNPROG; // RL24
   endfunction
   function automatic logic in_boot(input logic [15:0] a);
      return a >= BOOT_START;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // lock bits: {boot_lock_hi, boot_lock_lo, app_lock_hi, app_lock_lo} + general
   fspp_state_t state;
   fspp_state_t next_state;
   logic [5:0] lock_bits;
   logic [5:0] next_lock_bits;
   logic [1:0] app_f;
   logic [1:0] boot_f;
   logic       pc_boot;
   assign app_f   = lock_bits[1:0]; // RL1
   assign boot_f  = lock_bits[3:2]; // RL1
   assign pc_boot = in_boot(EXEC_PC_IN);

   // lock store only clears bits; chip erase sets all back
   always_comb begin
      next_lock_bits = lock_bits;
      if (CHIP_ERASE_IN)
         next_lock_bits = `FSPP_LOCK_RST; // RL2
      else if (STORE_REQ_IN && pc_boot && STORE_OP_IN == FSPP_OP_LOCK && state == FSPP_IDLE)
         next_lock_bits = lock_bits & LOCK_DATA_IN[5:0]; // RL2 RL21
   end

   ////////////////////////////////////////////////////////////////////////////
   // store path: permission and address capture
   logic [7:0]  cnt;
   logic [7:0]  next_cnt;
   logic [15:0] zaddr;
   logic        tgt_boot;
   logic        st_ok;
   logic        st_go;
   assign zaddr    = {ADDR_PAIR_HIGH_IN, ADDR_PAIR_LOW_IN}; // RL17
   assign tgt_boot = in_boot(zaddr);
   // general lock bits [5:4] deliberately not consulted
   always_comb begin
      st_ok = 1'b1; // RL3 RL4 RL5 RL10
      if (STORE_OP_IN != FSPP_OP_LOCK && STORE_OP_IN != FSPP_OP_FILL)
         st_ok = tgt_boot ? !no_write(boot_f) : !no_write(app_f); // RL6 RL7 RL11 RL12
   end
   assign st_go = STORE_REQ_IN && pc_boot && state == FSPP_IDLE && st_ok; // RL23

   logic [15:0] page_q;
   logic [15:0] word_q;
   logic [15:0] next_page;
   logic [15:0] next_word;
   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      next_page  = page_q;
      next_word  = word_q;
      unique case (state)
         FSPP_IDLE: begin
            if (st_go && STORE_OP_IN != FSPP_OP_LOCK) begin
               next_page  = zaddr >> WORD_BITS; // RL18 RL20
               next_word  = zaddr & ((16'h0001 << WORD_BITS) - 16'h0001); // RL18
               next_state = FSPP_BUSY;
               next_cnt   = 8'(OP_CYCLES - 1);
            end
         end
         FSPP_BUSY: begin
            if (cnt == 8'h00) next_state = FSPP_IDLE;
            else next_cnt = cnt - 8'h01;
         end
         default: next_state = FSPP_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // read path and interrupt masking
   logic [15:0] rd_addr;
   logic [15:0] rd_word;
   logic        rd_block;
   logic        irq_blk;
   assign rd_addr = zaddr;
   // byte address compared as a word address against the section boundary
   assign rd_word = {1'b0, rd_addr[15:1]}; // RL22
   always_comb begin
      rd_block = 1'b0;
      if (pc_boot && !in_boot(rd_word))
         rd_block = no_cross_read(app_f); // RL7 RL8
      else if (!pc_boot && in_boot(rd_word))
         rd_block = no_cross_read(boot_f); // RL12 RL13
   end
   always_comb begin
      irq_blk = 1'b0;
      if (!pc_boot && VECTORS_IN_BOOT_IN)
         irq_blk = no_cross_read(app_f); // RL9
      else if (pc_boot && !VECTORS_IN_BOOT_IN)
         irq_blk = no_cross_read(boot_f); // RL14
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         state              <= FSPP_IDLE;
         cnt                <= 8'h00;
         page_q             <= 16'h0000;
         word_q             <= 16'h0000;
         lock_bits          <= `FSPP_LOCK_RST;
         STORE_START_OUT    <= 1'b0;
         STORE_REFUSED_OUT  <= 1'b0;
         BUSY_OUT           <= 1'b0;
         PAGE_INDEX_OUT     <= 16'h0000;
         WORD_IN_PAGE_OUT   <= 16'h0000;
         READ_GRANT_OUT     <= 1'b0;
         READ_REFUSED_OUT   <= 1'b0;
         READ_WORD_ADDR_OUT <= 16'h0000;
         READ_HIGH_BYTE_OUT <= 1'b0;
         IRQ_BLOCK_OUT      <= 1'b0;
         RESET_VECTOR_OUT   <= `FSPP_APP_RESET_VEC;
         LOCK_BITS_OUT      <= `FSPP_LOCK_RST;
      end else if (CE_IN) begin
         state              <= next_state;
         cnt                <= next_cnt;
         page_q             <= next_page;
         word_q             <= next_word;
         lock_bits          <= next_lock_bits;
         STORE_START_OUT    <= st_go;
         STORE_REFUSED_OUT  <= STORE_REQ_IN && !st_go; // RL23
         BUSY_OUT           <= next_state == FSPP_BUSY;
         PAGE_INDEX_OUT     <= next_page;
         WORD_IN_PAGE_OUT   <= next_word;
         READ_GRANT_OUT     <= READ_REQ_IN && !rd_block;
         READ_REFUSED_OUT   <= READ_REQ_IN && rd_block;
         READ_WORD_ADDR_OUT <= rd_word; // RL22
         READ_HIGH_BYTE_OUT <= rd_addr[0]; // RL22
         IRQ_BLOCK_OUT      <= irq_blk;
         // fuse is an input only; no store path reaches it
         RESET_VECTOR_OUT   <= (BOOT_RESET_FUSE_IN == `FSPP_UNPROG) ? // RL15 RL16
                               `FSPP_APP_RESET_VEC : BOOT_START;
         LOCK_BITS_OUT      <= next_lock_bits;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   chk_app_write_lock: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // RL6
      CE_IN && STORE_REQ_IN && STORE_OP_IN == FSPP_OP_WRITE && !tgt_boot && app_f == 2'b10
      |=> !STORE_START_OUT) else $error("store into locked application started");
   chk_boot_write_lock: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // RL11
      CE_IN && STORE_REQ_IN && STORE_OP_IN == FSPP_OP_ERASE && tgt_boot && boot_f[0] == 1'b0
      |=> !STORE_START_OUT) else $error("store into locked boot started");
   chk_app_code_store: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // RL23
      CE_IN && STORE_REQ_IN && !pc_boot |=> STORE_REFUSED_OUT && !STORE_START_OUT)
      else $error("store from application code not refused");
   chk_boot_read_block: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // RL12
      CE_IN && READ_REQ_IN && !pc_boot && in_boot(rd_word) && boot_f == 2'b00
      |=> READ_REFUSED_OUT) else $error("application read of locked boot allowed");
   chk_app_read_block: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // RL8
      CE_IN && READ_REQ_IN && pc_boot && !in_boot(rd_word) && app_f == 2'b01
      |=> READ_REFUSED_OUT) else $error("boot read of locked application allowed");
   chk_read_free: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // RL5
      CE_IN && READ_REQ_IN && app_f == 2'b11 && boot_f == 2'b11 |=> READ_GRANT_OUT)
      else $error("unlocked read refused");
   chk_page_latch: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // RL20
      CE_IN && st_go && STORE_OP_IN != FSPP_OP_LOCK ##1 CE_IN && BUSY_OUT
      |=> $stable(PAGE_INDEX_OUT)) else $error("page changed while busy");
   chk_lock_sticky: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // RL2
      CE_IN && !CHIP_ERASE_IN |=> (LOCK_BITS_OUT & ~$past(LOCK_BITS_OUT)) == 6'h00)
      else $error("lock bit unprogrammed without chip erase");
   chk_reset_vector: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // RL15
      CE_IN && BOOT_RESET_FUSE_IN |=> RESET_VECTOR_OUT == 16'h0000)
      else $error("reset vector wrong for unprogrammed fuse");
   chk_irq_mask: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // RL9
      CE_IN && !pc_boot && VECTORS_IN_BOOT_IN && app_f[1] == 1'b0 |=> IRQ_BLOCK_OUT)
      else $error("interrupts not masked in application");

endmodule // fspp_top

// File: sim/fspp_cpu_model.sv
// cpu core model: issues store and program-read requests to the protection block
// assumes the bench clock; every request is launched and released on a falling edge
////////////////////////////////////////////////////////////////////////////////
module fspp_cpu_model
   import fspp_pkg::*;
(
   input  wire logic     clk_in,
   output logic          store_req_out,
   output fspp_op_t      store_op_out,
   output logic [7:0]    pair_high_out,
   output logic [7:0]    pair_low_out,
   output logic [7:0]    lock_data_out,
   output logic          read_req_out,
   output logic [15:0]   exec_pc_out
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [15:0] last_addr = 16'h0000;
   logic [7:0]  last_data = 8'hff;

   // idle lines at time zero
   initial begin
      store_req_out = 1'b0;
      read_req_out  = 1'b0;
      store_op_out  = FSPP_OP_FILL;
      {pair_high_out, pair_low_out} = 16'h0000;
      lock_data_out = 8'hff;
      exec_pc_out   = 16'h0000;
   end

   // move execution to another word address
   task automatic at(input logic [15:0] pc);
      exec_pc_out = pc;
   endtask

   // one request cycle; returns while the one-cycle answer stands
   // the caller keeps erase and write on the same page
   task automatic request(input logic st, input fspp_op_t op, input logic [15:0] addr,
                          input logic [7:0] data);
      store_req_out = st;
      read_req_out  = ~st;
      store_op_out  = op;
      {pair_high_out, pair_low_out} = addr;
      lock_data_out = data;
      last_addr     = addr;
      last_data     = data;
      @(negedge clk_in);
   endtask

   // end the request; the pair then shows the inverse of the last value
   task automatic release_bus();
      store_req_out = 1'b0;
      read_req_out  = 1'b0;
      {pair_high_out, pair_low_out} = ~last_addr;
      lock_data_out = ~last_data;
      @(negedge clk_in);
   endtask
endmodule // fspp_cpu_model

// File: sim/fspp_top_test.sv
// self-checking bench for the flash self-program protection block
// assumes the cpu model drives requests; the bench drives erase, fuse and vector inputs
////////////////////////////////////////////////////////////////////////////////
module fspp_top_test;
   import fspp_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [7:0] data; logic [15:0] wad; logic [1:0] wexp; logic [15:0] rpc;
      logic [15:0] rad; logic [1:0] rexp; logic vec; logic [15:0] ipc; logic iexp;
   } fspp_case_t;
   logic clk = 1'b0, nrst = 1'b0, erase = 1'b0, fuse = 1'b1, vec = 1'b0;
   logic sreq, rreq, start, sref, busy, grant, rref, rhigh, irq;
   fspp_op_t op;
   logic [7:0] ah, al, ld;
   logic [15:0] pc, page, word, rword, rvec;
   logic [5:0] lockb;
   int fails = 0;
   int num_checks = 0;
   // lock patterns: app modes 1-4, then boot modes 1-4
   fspp_case_t cases [8] = '{
      '{8'hff, 16'h0041, 2'b10, 16'h1c10, 16'h0081, 2'b10, 1'b1, 16'h0100, 1'b0},
      '{8'hfe, 16'h0041, 2'b01, 16'h1c10, 16'h0081, 2'b10, 1'b1, 16'h0100, 1'b0},
      '{8'hfc, 16'h0041, 2'b01, 16'h1c10, 16'h0081, 2'b01, 1'b1, 16'h0100, 1'b1},
      '{8'hfd, 16'h0041, 2'b10, 16'h1c10, 16'h0081, 2'b01, 1'b1, 16'h0100, 1'b1},
      '{8'hff, 16'hfc40, 2'b10, 16'h0100, 16'hfc41, 2'b10, 1'b0, 16'h1c10, 1'b0},
      '{8'hfb, 16'hfc40, 2'b01, 16'h0100, 16'hfc41, 2'b10, 1'b0, 16'h1c10, 1'b0},
      '{8'hf3, 16'hfc40, 2'b01, 16'h0100, 16'hfc41, 2'b01, 1'b0, 16'h1c10, 1'b1},
      '{8'hf7, 16'hfc40, 2'b10, 16'h0100, 16'hfc41, 2'b01, 1'b0, 16'h1c10, 1'b1}
   };

   // 50 MHz clock
   always #10 clk = ~clk;

   fspp_cpu_model i_cpu (.clk_in(clk), .store_req_out(sreq), .store_op_out(op),
      .pair_high_out(ah), .pair_low_out(al), .lock_data_out(ld), .read_req_out(rreq),
      .exec_pc_out(pc));
   fspp_top #(.OP_CYCLES(4)) i_dut (.CLOCK_IN(clk), .NRST_IN(nrst), .CE_IN(1'b1),
      .CHIP_ERASE_IN(erase), .BOOT_RESET_FUSE_IN(fuse), .VECTORS_IN_BOOT_IN(vec),
      .EXEC_PC_IN(pc), .STORE_REQ_IN(sreq), .STORE_OP_IN(op), .ADDR_PAIR_HIGH_IN(ah),
      .ADDR_PAIR_LOW_IN(al), .LOCK_DATA_IN(ld), .READ_REQ_IN(rreq),
      .STORE_START_OUT(start), .STORE_REFUSED_OUT(sref), .BUSY_OUT(busy),
      .PAGE_INDEX_OUT(page), .WORD_IN_PAGE_OUT(word), .READ_GRANT_OUT(grant),
      .READ_REFUSED_OUT(rref), .READ_WORD_ADDR_OUT(rword), .READ_HIGH_BYTE_OUT(rhigh),
      .IRQ_BLOCK_OUT(irq), .RESET_VECTOR_OUT(rvec), .LOCK_BITS_OUT(lockb));

   ////////////////////////////////////////////////////////////////////////////////
   // compare, request and closing tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic store(input fspp_op_t o, input logic [15:0] a, input logic [1:0] exp);
      i_cpu.request(1'b1, o, a, 8'hff);
      chk({14'h0000, start, sref}, {14'h0000, exp});
      i_cpu.release_bus();
   endtask
   task automatic rd(input logic [15:0] a, input logic [1:0] exp);
      i_cpu.request(1'b0, FSPP_OP_FILL, a, 8'hff);
      chk({14'h0000, grant, rref}, {14'h0000, exp});
      chk(rword, {1'b0, a[15:1]});
      chk({15'h0000, rhigh}, {15'h0000, a[0]});
      i_cpu.release_bus();
   endtask
   task automatic idle();
      for (int i = 0; i < 20 && busy !== 1'b0; i++) @(negedge clk);
      chk({15'h0000, busy}, 16'h0000);
   endtask
   task automatic lockset(input logic [7:0] d);
      i_cpu.at(16'h1c10);
      i_cpu.request(1'b1, FSPP_OP_LOCK, 16'h1234, d);
      chk({10'h000, lockb}, {10'h000, 6'h3f & d[5:0]});
      i_cpu.release_bus();
   endtask
   task automatic complete_run();
      $display("checks=%0d fails=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // watchdog against a hung run
   initial begin
      #100000;
      fails++;
      complete_run();
   end

   // main sequence
   initial begin
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      @(negedge clk);
      chk({10'h000, lockb}, 16'h003f);
      chk(rvec, 16'h0000);
      fuse = 1'b0;
      repeat (2) @(negedge clk);
      chk(rvec, 16'h1c00);
      i_cpu.at(16'h0100);
      store(FSPP_OP_WRITE, 16'h0041, 2'b01);
      i_cpu.at(16'h1c10);
      store(FSPP_OP_ERASE, 16'h0041, 2'b10);
      chk(page, 16'h0001);
      chk(word, 16'h0001);
      store(FSPP_OP_WRITE, 16'h0041, 2'b01);
      idle();
      store(FSPP_OP_WRITE, 16'h0041, 2'b10);
      idle();
      rd(16'h0081, 2'b10);
      lockset(8'hcf);
      store(FSPP_OP_WRITE, 16'h0041, 2'b10);
      idle();
      rd(16'h0080, 2'b10);
      foreach (cases[k]) begin
         erase = 1'b1;
         @(negedge clk);
         erase = 1'b0;
         @(negedge clk);
         chk({10'h000, lockb}, 16'h003f);
         lockset(cases[k].data);
         store(FSPP_OP_WRITE, cases[k].wad, cases[k].wexp);
         idle();
         i_cpu.at(cases[k].rpc);
         rd(cases[k].rad, cases[k].rexp);
         vec = cases[k].vec;
         i_cpu.at(cases[k].ipc);
         repeat (2) @(negedge clk);
         chk({15'h0000, irq}, {15'h0000, cases[k].iexp});
      end
      complete_run();
   end
endmodule // fspp_top_test
